/* File: hw/hdtc_top.sv */
// Half-duplex transcode host control: serial register port, audio FIFOs, frame engine.
// Assumes the host pauses the serial clock between address and data of a read,
// and between frames, long enough for the core clock to answer.
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Audio FIFO
// ************************************************************
module hdtc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             flush,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  // Fill level
  output logic [CW-1:0]         count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign count     = CW'(wr_ptr - rd_ptr);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
      end else begin
        if (push) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
      end
    end
  end

endmodule

// Summary of operation
// (RL1) Writing the flush code to the FIFO control register empties both audio FIFOs.
// (RL2) With the packed A-law input code selected, each input word holds packed A-law samples.
// (RL3) With the packed G.729A output code selected, results leave as packed coded frames.
// (RL4) A mode write with low mode bits zero only sets host-bus source and destination.
// (RL5) A mode write with the transcode code starts work, waiting for a full input frame.
// (RL6) A frame is eighty samples and starts only once eighty samples are buffered.
// (RL7) Packed input carries two samples per word, so a frame is forty host writes.
// (RL8) The threshold register counts input words read (high byte) and output words written (low byte).
// (RL9) A packed coded frame of eighty bits fills five output words.
// (RL10) An output threshold equal to the packed frame length interrupts once per coded frame.
// (RL11) The status register shows the output-count event at bit two and input-count at bit three.
// (RL12) On an output-count event the host reads one coded frame from the output FIFO.
// (RL13) On an input-count event the host promptly writes the next forty packed input words.
// (RL14) Transcoding continues while input suffices and the low mode bits stay unchanged.
// (RL15) The host may be interrupted on FIFO fill level or on word counts.
// (RL16) A count event stays in the status register until it is read, and its counter restarts.
module hdtc_top
  import hdtc_pkg::*;
#(
  parameter int IN_DEPTH  = 64,
  parameter int OUT_DEPTH = 8
) (
  // Core clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic ce,
  // Serial host bus
  input  wire logic sclk,
  input  wire logic csn,
  input  wire logic mosi,
  output logic      miso_out,
  output logic      miso_oe_n,
  // Host interrupt
  output logic      irq_n
);
  localparam int IN_CW  = $clog2(IN_DEPTH + 1);
  localparam int OUT_CW = $clog2(OUT_DEPTH + 1);
  localparam logic [IN_CW-1:0] IN_FULL = IN_CW'(IN_DEPTH);

  // ************************************************************
  // Serial link domain
  // ************************************************************
  logic            link_rst;
  logic [4:0]      bit_cnt;
  logic [23:0]     shift_in;
  logic [15:0]     shift_out;
  logic            frame_read;
  logic [7:0]      rd_addr;
  logic            rd_tgl;
  logic            wr_tgl;
  hdtc_cmd_t       cmd_hold;
  logic [15:0]     rd_hold;
  logic [7:0]      next_addr;

  // The frame select ends all per-frame state, since sclk may stop after the frame
  assign link_rst  = csn || !rstn;
  assign next_addr = {shift_in[6:0], mosi};
  assign miso_out  = shift_out[DATA_BITS-1];
  assign miso_oe_n = !(frame_read && (bit_cnt > ADDR_BITS[4:0]));

  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt    <= '0;
      shift_in   <= '0;
      frame_read <= 1'b0;
    end else begin
      shift_in <= {shift_in[22:0], mosi};
      if (bit_cnt != FRAME_BITS) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
      if (bit_cnt == ADDR_LAST_EDGE) begin
        frame_read <= hdtc_is_read(next_addr);
      end
    end
  end

  // Read word is taken from the core's holding register after the host's pause
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      shift_out <= '0;
    end else if (bit_cnt == ADDR_BITS[4:0]) begin
      shift_out <= rd_hold;
    end else begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  // Toggles and held words survive the frame select so the core can finish
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      rd_tgl   <= 1'b0;
      wr_tgl   <= 1'b0;
      rd_addr  <= '0;
      cmd_hold <= '0;
    end else if (!csn) begin
      if (bit_cnt == ADDR_LAST_EDGE && hdtc_is_read(next_addr)) begin
        rd_addr <= next_addr;
        rd_tgl  <= !rd_tgl;
      end
      if (bit_cnt == FRAME_BITS - 5'h01 && !frame_read) begin
        cmd_hold <= {shift_in[22:0], mosi};
        wr_tgl   <= !wr_tgl;
      end
    end
  end

  // ************************************************************
  // Crossing into the core domain
  // ************************************************************
  logic [1:0] wr_sync;
  logic [1:0] rd_sync;
  logic       wr_seen;
  logic       rd_seen;
  logic       wr_pulse;
  logic       rd_pulse;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_sync <= '0;
      rd_sync <= '0;
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
    end else if (ce) begin
      wr_sync <= {wr_sync[0], wr_tgl};
      rd_sync <= {rd_sync[0], rd_tgl};
      wr_seen <= wr_sync[1];
      rd_seen <= rd_sync[1];
    end
  end

  assign wr_pulse = ce && (wr_sync[1] != wr_seen);
  assign rd_pulse = ce && (rd_sync[1] != rd_seen);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [15:0] thresholds;
  logic [15:0] in_format;
  logic [15:0] out_format;
  logic [15:0] mode_word;
  logic        lvl_en_in;
  logic        lvl_en_out;
  logic        flush_in;
  logic        flush_out;
  hdtc_mode_t  mode;
  logic        run;

  assign flush_in  = wr_pulse && cmd_hold.addr == ADDR_FLUSH && cmd_hold.data[FLUSH_IN_BIT];  // RL1
  assign flush_out = wr_pulse && cmd_hold.addr == ADDR_FLUSH && cmd_hold.data[FLUSH_OUT_BIT]; // RL1
  assign mode      = hdtc_mode_t'(mode_word[1:0]);
  assign run       = (mode == MODE_XCODE) && // RL5
                     (mode_word[MODE_SRC_LSB +: 4] == ROUTE_HOST) &&
                     (mode_word[MODE_DST_LSB +: 4] == ROUTE_HOST); // RL4

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      thresholds <= RESET_WORD;
      in_format  <= RESET_WORD;
      out_format <= RESET_WORD;
      mode_word  <= RESET_WORD;
      lvl_en_in  <= 1'b0;
      lvl_en_out <= 1'b0;
    end else if (wr_pulse) begin
      unique case (cmd_hold.addr)
        ADDR_THRESHOLD:  thresholds <= cmd_hold.data; // RL8
        ADDR_IN_FORMAT:  in_format  <= cmd_hold.data;
        ADDR_OUT_FORMAT: out_format <= cmd_hold.data;
        ADDR_MODE:       mode_word  <= cmd_hold.data; // RL4
        ADDR_FLUSH: begin
          lvl_en_in  <= cmd_hold.data[LVL_EN_IN_BIT]; // RL15
          lvl_en_out <= cmd_hold.data[LVL_EN_OUT_BIT];
        end
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Audio FIFOs
  // ************************************************************
  logic [15:0]       in_head;
  logic              in_valid;
  logic              in_pop;
  logic [IN_CW-1:0]  in_count;
  logic [15:0]       out_word;
  logic              out_push;
  logic              out_ready;
  logic [15:0]       out_head;
  logic              out_valid;
  logic              out_pop;
  logic              out_taken;

  // Writes to a full input FIFO are lost; the host paces itself by the count event
  hdtc_fifo #(.WIDTH(16), .DEPTH(IN_DEPTH)) u_in_fifo (
    .clk       (mclk),
    .rstn      (rstn),
    .ce        (ce),
    .flush     (flush_in),
    .in_data   (cmd_hold.data),
    .in_valid  (wr_pulse && hdtc_is_in_word(cmd_hold.addr)),
    .in_ready  (),
    .out_data  (in_head),
    .out_valid (in_valid),
    .out_ready (in_pop),
    .count     (in_count)
  );

  hdtc_fifo #(.WIDTH(16), .DEPTH(OUT_DEPTH)) u_out_fifo (
    .clk       (mclk),
    .rstn      (rstn),
    .ce        (ce),
    .flush     (flush_out),
    .in_data   (out_word),
    .in_valid  (out_push),
    .in_ready  (out_ready),
    .out_data  (out_head),
    .out_valid (out_valid),
    .out_ready (out_pop),
    .count     ()
  );

  assign out_pop   = rd_pulse && (rd_addr == ADDR_OUT_WORD || rd_addr == ADDR_OUT_WORD_ALT);
  assign out_taken = out_push && out_ready;

  // ************************************************************
  // Frame engine
  // ************************************************************
  hdtc_eng_t   state;
  logic [6:0]  in_words;
  logic [6:0]  out_words;
  logic [6:0]  fr_in;
  logic [6:0]  fr_out;
  logic [6:0]  taken;
  logic [6:0]  slot;
  logic [15:0] acc [OUT_WORDS_MAX];

  assign in_words  = (in_format == FMT_ALAW_PACKED) ? IN_WORDS_PACKED : IN_WORDS_UNPACKED; // RL2 RL7
  assign out_words = (out_format == FMT_G729_PACKED) ? OUT_WORDS_PACKED
                                                     : OUT_WORDS_UNPACKED; // RL3 RL9
  assign in_pop    = ce && (state == ENG_GATHER) && in_valid;
  assign out_push  = (state == ENG_EMIT);
  assign out_word  = acc[slot[3:0]];

  // A frame already under way is finished even if the mode changes; the next is not begun
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state  <= ENG_IDLE;
      fr_in  <= IN_WORDS_PACKED;
      fr_out <= OUT_WORDS_PACKED;
      taken  <= '0;
      slot   <= '0;
    end else if (ce) begin
      if (flush_in || flush_out) begin
        state <= ENG_IDLE;
      end else begin
        unique case (state)
          ENG_IDLE: begin
            if (run && in_count >= IN_CW'(in_words)) begin // RL5 RL6 RL14
              state  <= ENG_GATHER;
              fr_in  <= in_words;
              fr_out <= out_words;
              taken  <= '0;
              slot   <= '0;
            end
          end
          ENG_GATHER: begin
            if (in_pop) begin
              taken <= taken + 1'b1;
              slot  <= (slot == fr_out - 7'h01) ? '0 : slot + 1'b1;
              if (taken == fr_in - 7'h01) begin
                state <= ENG_EMIT;
                slot  <= '0;
              end
            end
          end
          ENG_EMIT: begin
            if (out_ready) begin // RL9
              slot <= slot + 1'b1;
              if (slot == fr_out - 7'h01) begin
                state <= ENG_IDLE; // RL14
              end
            end
          end
          default: state <= ENG_IDLE;
        endcase
      end
    end
  end

  // Stand-in coder: each coded word folds the input words of its slot
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < OUT_WORDS_MAX; i++) begin
        acc[i] <= RESET_WORD;
      end
    end else if (ce) begin
      if (state == ENG_IDLE) begin
        for (int i = 0; i < OUT_WORDS_MAX; i++) begin
          acc[i] <= RESET_WORD;
        end
      end else if (in_pop) begin
        acc[slot[3:0]] <= acc[slot[3:0]] ^ in_head;
      end
    end
  end

  // ************************************************************
  // Count events and status
  // ************************************************************
  logic [7:0] in_cnt;
  logic [7:0] out_cnt;
  logic       in_evt;
  logic       out_evt;
  logic       cnt_in_flag;
  logic       cnt_out_flag;
  logic       lvl_in;
  logic       status_rd;
  logic [15:0] status_word;

  assign in_evt  = in_pop && thresholds[15:8] != 8'h00 && in_cnt + 8'h01 == thresholds[15:8]; // RL8
  assign out_evt = ce && out_taken && thresholds[7:0] != 8'h00
                   && out_cnt + 8'h01 == thresholds[7:0]; // RL8 RL10
  assign lvl_in  = (IN_FULL - in_count) >= IN_CW'(in_words); // RL15
  assign status_rd = rd_pulse && rd_addr == ADDR_STATUS;

  always_comb begin
    status_word               = RESET_WORD;
    status_word[ST_LVL_OUT]   = out_valid;
    status_word[ST_LVL_IN]    = lvl_in;
    status_word[ST_COUNT_OUT] = cnt_out_flag; // RL11
    status_word[ST_COUNT_IN]  = cnt_in_flag;  // RL11
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      in_cnt  <= '0;
      out_cnt <= '0;
    end else if (ce) begin
      if (flush_in || in_evt) begin
        in_cnt <= '0; // RL16
      end else if (in_pop) begin
        in_cnt <= in_cnt + 8'h01;
      end
      if (flush_out || out_evt) begin
        out_cnt <= '0; // RL16
      end else if (out_taken) begin
        out_cnt <= out_cnt + 8'h01;
      end
    end
  end

  // An event in the same cycle as the clearing read survives it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_in_flag  <= 1'b0;
      cnt_out_flag <= 1'b0;
    end else if (ce) begin
      cnt_in_flag  <= in_evt || (cnt_in_flag && !status_rd);   // RL16
      cnt_out_flag <= out_evt || (cnt_out_flag && !status_rd); // RL16
    end
  end

  // ************************************************************
  // Read answers and interrupt
  // ************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_hold <= RESET_WORD;
    end else if (rd_pulse) begin
      if (status_rd) begin
        rd_hold <= status_word; // RL11
      end else begin
        rd_hold <= out_valid ? out_head : RESET_WORD;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_n <= 1'b1;
    end else if (ce) begin
      irq_n <= !(cnt_in_flag || cnt_out_flag || (lvl_en_out && out_valid)
                 || (lvl_en_in && lvl_in)); // RL15
    end
  end

endmodule

`default_nettype wire

/* File: hw/hdtc_pkg.sv */
// Shared constants and types of the half-duplex transcode host control block.
// Assumes a register-addressed serial host bus: 8 address bits, then 16 data bits, MSB first.
package hdtc_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_IN_WORD      = 8'h48;
  localparam logic [7:0] ADDR_IN_WORD_ALT  = 8'h49;
  localparam logic [7:0] ADDR_OUT_WORD     = 8'h4c;
  localparam logic [7:0] ADDR_OUT_WORD_ALT = 8'h4d;
  localparam logic [7:0] ADDR_FLUSH        = 8'h50;
  localparam logic [7:0] ADDR_THRESHOLD    = 8'h51;
  localparam logic [7:0] ADDR_IN_FORMAT    = 8'h54;
  localparam logic [7:0] ADDR_OUT_FORMAT   = 8'h56;
  localparam logic [7:0] ADDR_MODE         = 8'h6b;
  localparam logic [7:0] ADDR_STATUS       = 8'h7e;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int          FLUSH_IN_BIT    = 15;
  localparam int          LVL_EN_IN_BIT   = 14;
  localparam int          FLUSH_OUT_BIT   = 7;
  localparam int          LVL_EN_OUT_BIT  = 6;
  localparam logic [15:0] FMT_ALAW_PACKED = 16'h0011;
  localparam logic [15:0] FMT_G729_PACKED = 16'h0010;
  localparam int          MODE_DST_LSB    = 4;
  localparam int          MODE_SRC_LSB    = 8;
  localparam logic [3:0]  ROUTE_HOST      = 4'h1;
  localparam int          ST_LVL_OUT      = 0;
  localparam int          ST_LVL_IN       = 1;
  localparam int          ST_COUNT_OUT    = 2;
  localparam int          ST_COUNT_IN     = 3;
  localparam logic [15:0] RESET_WORD      = 16'h0000;

  // ************************************************************
  // Frame geometry
  // ************************************************************
  localparam logic [6:0] IN_WORDS_PACKED    = 7'h28;
  localparam logic [6:0] IN_WORDS_UNPACKED  = 7'h50;
  localparam logic [6:0] OUT_WORDS_PACKED   = 7'h05;
  localparam logic [6:0] OUT_WORDS_UNPACKED = 7'h0a;
  localparam int         OUT_WORDS_MAX      = 10;
  localparam int         ADDR_BITS          = 8;
  localparam int         DATA_BITS          = 16;
  localparam logic [4:0] ADDR_LAST_EDGE     = 5'h07;
  localparam logic [4:0] FRAME_BITS         = 5'h18;

  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_XCODE  = 2'b01,
    MODE_ENCDEC = 2'b10,
    MODE_FULL   = 2'b11
  } hdtc_mode_t;

  typedef enum logic [1:0] {
    ENG_IDLE   = 2'b00,
    ENG_GATHER = 2'b01,
    ENG_EMIT   = 2'b10
  } hdtc_eng_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } hdtc_cmd_t;

  function automatic logic hdtc_is_read(input logic [7:0] a);
    return (a == ADDR_OUT_WORD) || (a == ADDR_OUT_WORD_ALT) || (a == ADDR_STATUS);
  endfunction

  function automatic logic hdtc_is_in_word(input logic [7:0] a);
    return (a == ADDR_IN_WORD) || (a == ADDR_IN_WORD_ALT);
  endfunction

endpackage

/* File: verification/hdtc_top_assertions.sv */
// Concurrent checks on the ports of the transcode host control block.
// Assumes the host keeps sclk low between frames and pauses it after the address.
`timescale 1ns/100ps
`default_nettype none
module hdtc_top_assertions (
  // Core side
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // Serial side and host interrupt
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe_n,
  input wire logic irq_n
);
  // ************************************************************
  // Frame tracking
  // ************************************************************
  logic [4:0] edge_cnt;
  logic [7:0] addr_sh;
  logic [3:0] idle_cnt;
  logic       rd_addr;

  assign rd_addr = (addr_sh == 8'h4c) || (addr_sh == 8'h4d) || (addr_sh == 8'h7e);

  always_ff @(posedge sclk or posedge csn) begin
    if (csn) edge_cnt <= 5'h00;
    else if (edge_cnt != 5'h1f) edge_cnt <= edge_cnt + 5'h01;
  end

  always_ff @(posedge sclk or posedge csn) begin
    if (csn) addr_sh <= 8'h00;
    else if (edge_cnt < 5'h08) addr_sh <= {addr_sh[6:0], mosi};
  end

  // Host quiet long enough that no late write can still land
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) idle_cnt <= 4'h0;
    else if (!csn) idle_cnt <= 4'h0;
    else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
  end

  a_oe_addr_phase: assert property (@(posedge sclk) disable iff (!rstn)
    !csn && edge_cnt < 5'h09 |-> miso_oe_n) else $error("miso driven before data phase");
  a_oe_read_data: assert property (@(posedge sclk) disable iff (!rstn)
    !csn && edge_cnt >= 5'h09 && rd_addr |-> !miso_oe_n) else $error("read data not driven");
  a_oe_write_quiet: assert property (@(posedge sclk) disable iff (!rstn)
    !csn && edge_cnt >= 5'h09 && !rd_addr |-> miso_oe_n) else $error("miso driven on write");
  a_oe_idle_csn: assert property (@(posedge mclk) disable iff (!rstn)
    csn |-> miso_oe_n) else $error("miso driven while deselected");
  a_irq_holds: assert property (@(posedge mclk) disable iff (!rstn)
    ce && !irq_n && idle_cnt >= 4'h8 |=> !irq_n) else $error("interrupt dropped unread");
  a_irq_ce_freeze: assert property (@(posedge mclk) disable iff (!rstn)
    !ce |=> $stable(irq_n)) else $error("interrupt moved while frozen");
  a_irq_reset_idle: assert property (@(posedge mclk)
    $rose(rstn) |-> irq_n) else $error("interrupt active after reset");
  a_miso_reset_idle: assert property (@(posedge mclk)
    $rose(rstn) |-> miso_oe_n && !miso_out) else $error("miso active after reset");
endmodule

bind hdtc_top hdtc_top_assertions u_hdtc_chk (
  .mclk(mclk), .rstn(rstn), .ce(ce), .sclk(sclk), .csn(csn), .mosi(mosi),
  .miso_out(miso_out), .miso_oe_n(miso_oe_n), .irq_n(irq_n)
);
`default_nettype wire

/* File: verification/hdtc_host.sv */
// Host model: 24-edge serial frames, MSB first, sclk still between frames.
// Assumes a 6 ns link clock and a device that answers reads within the pause.
`timescale 1ns/100ps
`default_nettype none
module hdtc_host (
  // Serial bus
  output logic      sclk,
  output logic      csn,
  output logic      mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe_n
);
  logic last_bit;
  logic miso_line;

  // Undriven line shows garbage, never the last valid bit
  assign miso_line = miso_oe_n ? ~last_bit : miso_out;

  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
    last_bit = 1'b0;
  end

  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] sh;
    sh = {a, d};
    q = 16'h0000;
    csn = 1'b0;
    for (int i = 0; i < 24; i++) begin
      mosi = sh[23-i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
      if (i >= 8) begin
        q = {q[14:0], miso_line};
        last_bit = miso_line;
      end
      // Core needs time to fetch the read word
      if (i == 7) #260;
    end
    csn = 1'b1;
    #300;
  endtask
endmodule
`default_nettype wire

/* File: verification/hdtc_top_bench.sv */
// Self-checking bench for the transcode host control block.
// Assumes the stand-in coder: coded word i is the XOR of input words j with j mod 5 = i.
`timescale 1ns/100ps
`default_nettype none
module hdtc_top_bench
  import hdtc_pkg::*;
();
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce   = 1'b1;
  logic sclk;
  logic csn;
  logic mosi;
  logic miso_out;
  logic miso_oe_n;
  logic irq_n;
  int   error_cnt = 0;
  int   check_count = 0;

  always #25 mclk = ~mclk;

  hdtc_top uut (.mclk(mclk), .rstn(rstn), .ce(ce), .sclk(sclk), .csn(csn), .mosi(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .irq_n(irq_n));
  hdtc_host u_host (.sclk(sclk), .csn(csn), .mosi(mosi), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    u_host.xfer(a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    u_host.xfer(a, 16'h0000, q);
  endtask

  function automatic logic [15:0] word_of(input int f, input int j);
    return 16'(f * 16'h1357 + j * 16'h0f21 + 16'h00a5);
  endfunction

  task automatic feed(input int f, input int from, input int upto);
    for (int j = from; j < upto; j++) wr((j % 2) ? ADDR_IN_WORD_ALT : ADDR_IN_WORD, word_of(f, j));
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_n !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    repeat (20) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0000);
  endtask

  task automatic drain_frame(input int f);
    logic [15:0] q;
    logic [15:0] e;
    for (int i = 0; i < 5; i++) begin
      e = 16'h0000;
      for (int j = i; j < 40; j += 5) e ^= word_of(f, j);
      rd((i % 2) ? ADDR_OUT_WORD_ALT : ADDR_OUT_WORD, q);
      check(q, e);
    end
  endtask

  task automatic status_is(input logic [3:0] e);
    logic [15:0] q;
    rd(ADDR_STATUS, q);
    check({12'h000, q[3:0]}, {12'h000, e});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic s_prime();
    logic [15:0] q;
    wr(ADDR_FLUSH, 16'h8080);
    wr(ADDR_IN_FORMAT, FMT_ALAW_PACKED);
    wr(ADDR_OUT_FORMAT, FMT_G729_PACKED);
    wr(ADDR_MODE, 16'h0110);
    feed(0, 0, 40);
    wr(8'h60, 16'hffff);
    rd(8'h55, q);
    repeat (20) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0001);
    status_is(4'b0000);
  endtask

  task automatic s_first_frame();
    logic [15:0] q;
    wr(ADDR_THRESHOLD, 16'h2805);
    wr(ADDR_MODE, 16'h0111);
    wait_irq();
    status_is(4'b1111);
    repeat (4) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0001);
    drain_frame(0);
    rd(ADDR_OUT_WORD, q);
    check(q, 16'h0000);
    status_is(4'b0010);
  endtask

  task automatic s_stall_flush();
    feed(9, 0, 7);
    wr(ADDR_FLUSH, 16'h8080);
    feed(1, 0, 39);
    repeat (60) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0001);
    status_is(4'b0000);
    feed(1, 39, 40);
    wait_irq();
    ce = 1'b0;
    repeat (10) @(negedge mclk);
    ce = 1'b1;
    check({15'h0, irq_n}, 16'h0000);
    status_is(4'b1111);
    drain_frame(1);
  endtask

  task automatic s_fill_drain();
    logic [15:0] q;
    // Ten coded words against an eight-deep output buffer forces a stall
    feed(2, 0, 40);
    feed(3, 0, 40);
    repeat (100) @(negedge mclk);
    drain_frame(2);
    repeat (100) @(negedge mclk);
    drain_frame(3);
    rd(ADDR_OUT_WORD_ALT, q);
    check(q, 16'h0000);
    status_is(4'b1110);
  endtask

  task automatic s_stop();
    wr(ADDR_MODE, 16'h0110);
    feed(4, 0, 40);
    repeat (100) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0001);
    status_is(4'b0000);
  endtask

  task automatic s_level();
    // An emptied input has room for a frame; that level is not cleared by reading status
    wr(ADDR_FLUSH, 16'hc000);
    repeat (20) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0000);
    status_is(4'b0010);
    @(negedge mclk);
    check({15'h0, irq_n}, 16'h0000);
    wr(ADDR_FLUSH, 16'h0000);
    repeat (20) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0001);
    // Unpacked input needs eighty words, so forty must not start a frame
    wr(ADDR_IN_FORMAT, 16'h0000);
    wr(ADDR_MODE, 16'h0111);
    feed(5, 0, 40);
    repeat (100) @(negedge mclk);
    check({15'h0, irq_n}, 16'h0001);
    status_is(4'b0000);
  endtask

  // ************************************************************
  // Sequence and watchdog
  // ************************************************************
  initial begin
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    repeat (4) @(negedge mclk);
    s_prime();
    s_first_frame();
    s_stall_flush();
    s_fill_drain();
    s_stop();
    s_level();
    test_done();
  end

  // Runs near 240 us; about four times that means a hang
  initial begin
    #1000000;
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
